// ===== rtl/program_memory_fetch.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
module program_memory_fetch
  import pm_read_pkg::*;
#(
  parameter int unsigned mem_addr_w = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [mem_addr_w-1:0] mem_addr_o,
  input wire logic [word_w-1:0] mem_data_i,
  output logic busy_o
);
  // ----------------------------------------
  // array model of the word store
  // ----------------------------------------
  logic [word_w-1:0] rom [2**mem_addr_w];
  initial begin
    for (int i = 0; i < 2**mem_addr_w; i++) begin
      rom[i] = '0;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  fetch_state_e state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [7:0] addr_low_ff, nxt_addr_low;
  logic [7:0] addr_high_ff, nxt_addr_high;
  logic [5:0] data_high_ff, nxt_data_high;
  logic [7:0] data_low_ff, nxt_data_low;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req;
  logic wr;
  logic [9:0] idx;
  logic [addr_w-1:0] word_addr;
  logic [mem_addr_w-1:0] phys_addr;
  logic [word_w-1:0] fetched;

  assign req = cyc_i & stb_i & ~ack_ff;
  assign wr = req & we_i & sel_i[0];
  assign idx = adr_i[11:2];
  assign word_addr = {addr_high_ff[addr_w-9:0], addr_low_ff};
  // high bits beyond the real array are dropped, so a small part aliases
  assign phys_addr = word_addr[mem_addr_w-1:0];
  assign mem_addr_o = phys_addr;
  assign fetched = mem_data_i | rom[phys_addr];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // one strobe per register keeps each group's next-state logic small
  logic wr_addr_low;
  logic wr_addr_high;
  logic wr_data_low;
  logic wr_data_high;
  logic wr_control;
  logic start_req;
  logic fetch_done;

  assign wr_addr_low = wr & (idx == program_read_addr_low_idx);
  assign wr_addr_high = wr & (idx == program_read_addr_high_idx);
  assign wr_data_low = wr & (idx == program_read_data_low_idx);
  assign wr_data_high = wr & (idx == program_read_data_high_idx);
  assign wr_control = wr & (idx == program_read_control_idx);
  // only a one starts; a zero write is a no-op
  assign start_req = wr_control & dat_i[start_bit];
  assign fetch_done = (state_ff == busy) && (cnt_ff == 2'h0);

  // ----------------------------------------
  // address registers
  // ----------------------------------------
  always_comb begin
    nxt_addr_low = addr_low_ff;
    nxt_addr_high = addr_high_ff;
    if (wr_addr_low) begin
      nxt_addr_low = dat_i[7:0];
    end
    if (wr_addr_high) begin
      // all eight bits read back; only the low ones reach the array
      nxt_addr_high = dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low_ff <= byte_reset;
      addr_high_ff <= byte_reset;
    end else begin
      addr_low_ff <= nxt_addr_low;
      addr_high_ff <= nxt_addr_high;
    end
  end

  // ----------------------------------------
  // fetch sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      idle: begin
        if (start_req) begin
          nxt_state = busy;
          nxt_cnt = 2'(fetch_cycles - 1);
        end
      end
      busy: begin
        // repeated start writes fall through here unheard
        if (fetch_done) begin
          nxt_state = idle;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= idle;
      cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_comb begin
    nxt_data_low = data_low_ff;
    nxt_data_high = data_high_ff;
    if (wr_data_low) begin
      nxt_data_low = dat_i[7:0];
    end
    if (wr_data_high) begin
      nxt_data_high = dat_i[5:0];
    end
    // completion beats a software write in the same cycle
    if (fetch_done) begin
      {nxt_data_high, nxt_data_low} = fetched;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_high_ff <= 6'h00;
      data_low_ff <= byte_reset;
    end else begin
      data_high_ff <= nxt_data_high;
      data_low_ff <= nxt_data_low;
    end
  end

  // ----------------------------------------
  // bus response
  // ----------------------------------------
  // read data is registered, so ack and data appear in the same cycle
  always_comb begin
    nxt_ack = req;
    nxt_rdata = rdata_ff;
    if (req) begin
      unique case (idx)
        program_read_control_idx: nxt_rdata = {24'h0, control_fixed | {7'h0, state_ff == busy}};
        program_read_addr_low_idx: nxt_rdata = {24'h0, addr_low_ff};
        program_read_addr_high_idx: nxt_rdata = {24'h0, addr_high_ff};
        program_read_data_low_idx: nxt_rdata = {24'h0, data_low_ff};
        program_read_data_high_idx: nxt_rdata = {26'h0, data_high_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;
  assign busy_o = (state_ff == busy);
endmodule

// ===== pkg/pm_read_pkg.sv
// How it works
// - program words readable anytime via control, address and data registers
// - fetched word is 14 bits, split over data high and data low registers
// - fetch address is 12 bits from address high and address low registers
// - address scheme covers up to 4K words, locations 0h to fffh
// - upper unused address-high bits are ignored for smaller memories
// - writing 1 to control bit 0 starts a fetch
// - software can only set the start bit; writing 0 changes nothing
// - hardware clears the start bit when the fetch finishes
// - a fetch completes two cycles after the start bit is set
// - on completion data registers take the addressed word
package pm_read_pkg;
  // ----------------------------------------
  // register offsets (index, byte addr = 4x)
  // ----------------------------------------
  localparam logic [9:0] program_read_data_low_idx = 10'h10c;
  localparam logic [9:0] program_read_data_high_idx = 10'h10e;
  localparam logic [9:0] program_read_addr_low_idx = 10'h10d;
  localparam logic [9:0] program_read_addr_high_idx = 10'h10f;
  localparam logic [9:0] program_read_control_idx = 10'h18c;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned word_w = 14;
  localparam int unsigned addr_w = 12;
  localparam int unsigned full_addr_w = 14;
  localparam int unsigned start_bit = 0;
  localparam int unsigned reserved_bit = 7;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [7:0] control_fixed = 8'h80;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned fetch_cycles = 2;
  typedef enum logic [1:0] {idle, busy} fetch_state_e;
endpackage

// ===== dv/pm_mem_model.sv
`timescale 1ns/10ps
module pm_mem_model (
  input wire logic [10:0] addr_i,
  output logic [13:0] data_o
);
  // neighbours differ, so an address slip shows
  assign data_o = {addr_i[2:0], addr_i} ^ 14'h1234;
endmodule

// ===== dv/pm_read_chk.sv
`timescale 1ns/10ps
module pm_read_chk
  import pm_read_pkg::*;
#(parameter int unsigned mem_addr_w = 11) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && !ack_o;
  wire wr = take && we_i && sel_i[0];
  wire rdc = take && !we_i;
  wire ctl = adr_i[11:2] == program_read_control_idx;
  sequence fetch_s;
    busy_o ##1 !busy_o;
  endsequence
  ack_take_a: assert property (take |=> ack_o) else $error("ack late");
  ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  ack_idle_a: assert property (!stb_i |=> !ack_o) else $error("stray ack");
  start_fetch_a: assert property (wr && ctl && dat_i[0] && !busy_o |=> busy_o ##1 fetch_s)
    else $error("no fetch");
  busy_len_a: assert property ($rose(busy_o) |=> fetch_s) else $error("fetch len");
  zero_wr_a: assert property (wr && ctl && !dat_i[0] && !busy_o |=> !busy_o)
    else $error("zero started");
  ctl_rd_a: assert property (rdc && ctl |=> dat_o == {24'h0, 7'h40, $past(busy_o)})
    else $error("control value");
  hi_rd_a: assert property (rdc && adr_i[11:2] == program_read_data_high_idx
    |=> dat_o[31:6] == 26'h0) else $error("high bits");
endmodule

// ===== dv/testbench.sv
`timescale 1ns/10ps
module testbench
  import pm_read_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, busy_o;
  logic [11:0] adr_i = 12'h000, a;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [10:0] mem_addr_o;
  logic [13:0] mem_data_i, w;
  int mismatches = 0, comparisons = 0, cycles = 0;
  program_memory_fetch u_program_memory_fetch (.*);
  pm_mem_model u_pm_mem_model (.addr_i(mem_addr_o), .data_o(mem_data_i));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ---
  // bus tasks
  // ---
  task automatic wb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'($urandom), d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [9:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 8'h0);
    comparisons++;
    if (rd !== e) begin
      mismatches++;
      $display("MISMATCH %0t reg %h got %h exp %h", $time, idx, rd, e);
    end
  endtask
  task automatic cb(input logic e);
    comparisons++;
    if (busy_o !== e) begin
      mismatches++;
      $display("MISMATCH %0t busy got %b exp %b", $time, busy_o, e);
    end
  endtask
  function automatic logic [13:0] exp_word(input logic [11:0] addr);
    // the top address bit is beyond an 11-bit array and must not matter
    return {addr[2:0], addr[10:0]} ^ 14'h1234;
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hef88));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(program_read_control_idx, 32'h80);
    rc(10'h000, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 20; i++) begin
      a = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      w = exp_word(a);
      wb(1'b1, program_read_addr_low_idx, a[7:0]);
      wb(1'b1, program_read_addr_high_idx, {4'($urandom), a[11:8]});
      wb(1'b1, program_read_control_idx, 8'h01);
      cb(1'b1);
      @(posedge clk_i);
      cb(1'b0);
      wb(1'b1, program_read_control_idx, 8'h00);
      cb(1'b0);
      rc(program_read_control_idx, 32'h80);
      rc(program_read_data_low_idx, {24'h0, w[7:0]});
      rc(program_read_data_high_idx, {26'h0, w[13:8]});
    end
    $display("fetch test done");
    give_verdict();
  end
endmodule
bind program_memory_fetch pm_read_chk #(.mem_addr_w(mem_addr_w)) u_pm_read_chk (.*);
